// ==== logic/qdl_channel.sv ====
// One DAC channel: 12-bit shift register, transparent holding register and code decode
`include "qdl_defs.svh"
`default_nettype none
module qdl_channel
   import qdl_pkg::*;
#(
   parameter int W = `QDL_CODE_W
) (
   input  wire logic         clk,
   input  wire logic         rst,
   input  wire logic         shift_en,
   input  wire logic         ser_in,
   input  wire logic         load_n,
   input  wire qdl_mode_e    mode,
   output logic [W-1:0]      code,
   output logic              neg,
   output logic [W-1:0]      mag
);
   logic [W-1:0] shift_q;
   logic [W-1:0] hold_q;

   // Oldest bit falls off the top; MSB arrives first and ends in bit W-1
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         shift_q <= '0;
      end else if (shift_en) begin
         shift_q <= {shift_q[W-2:0], ser_in}; // [RULE1] [RULE6] [RULE14]
      end
   end

   // Transparent while low: the register follows each shift step, hence glitches
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hold_q <= '0;
      end else if (!load_n) begin
         hold_q <= shift_en ? {shift_q[W-2:0], ser_in} : shift_q; // [RULE3] [RULE12] [RULE7]
      end
   end

   assign code = hold_q;

   // Sign and magnitude of output, in units of Vref/4096 (unipolar) or Vref/2048
   always_comb begin
      if (mode == QDL_UNIPOLAR) begin
         neg = (hold_q != '0);                      // [RULE9]
         mag = hold_q;                              // [RULE9]
      end else begin
         neg = !hold_q[W-1];                        // [RULE10]
         mag = hold_q[W-1] ? {1'b0, hold_q[W-2:0]} // [RULE10]
                           : W'(`QDL_BIP_ZERO) - hold_q;
      end
   end
endmodule
`default_nettype wire

// ==== logic/qdl_defs.svh ====
// Constants for the quad serial DAC load interface
`ifndef QDL_DEFS_SVH
`define QDL_DEFS_SVH
`define QDL_CODE_W        12
`define QDL_NCH           4
`define QDL_CODE_MSB      11
`define QDL_FULL_SCALE    4096
`define QDL_BIP_ZERO      12'h800
`define QDL_CLK_PERIOD_NS 8
`define QDL_LOAD_DELAY_NS 30
// Least time rounds up to whole cycles
`define QDL_LOAD_DELAY_CYC ((`QDL_LOAD_DELAY_NS + `QDL_CLK_PERIOD_NS - 1) / `QDL_CLK_PERIOD_NS)
`define QDL_SCLK_DIV      4
`endif

// ==== logic/qdl_device.sv ====
// Quad DAC device end: four channels on shared or separate serial clocks
//
// What this block and the host end do
// [RULE1] Bits shift in MSB first on rising clock
// [RULE2] Host pulls strobe low after full code
// [RULE3] Holding register transparent low, latched high
// [RULE4] Host waits 30ns after last edge
// [RULE5] Shared clock or per-channel clocks by variant
// [RULE6] Each channel reads only its data pin
// [RULE7] One strobe changes only its channel
// [RULE8] Common strobe updates all channels together
// [RULE9] Unipolar: straight binary, code/4096, inverted
// [RULE10] Bipolar: offset binary, 0x800 is zero
// [RULE11] Host flips MSB for twos complement
// [RULE12] Strobe active low transfers shift register
// [RULE13] Host keeps strobes high while shifting
// [RULE14] Shift register keeps last twelve bits
`include "qdl_defs.svh"
`default_nettype none
module qdl_device
   import qdl_pkg::*;
#(
   parameter int  NCH        = `QDL_NCH,
   parameter int  W          = `QDL_CODE_W,
   parameter bit  SHARED_CLK = 1'b0
) (
   input  wire logic            REF_CLK,
   input  wire logic            RESET,
   qdl_if.dev                   LINK,
   input  wire qdl_mode_e       MODE,
   output logic [NCH*W-1:0]     CODE,
   output logic [NCH-1:0]       OUT_NEG,
   output logic [NCH*W-1:0]     CHANNEL_CURRENT_OUT
);
   logic [NCH-1:0] sclk_q;
   logic [NCH-1:0] sclk_eff;
   logic [NCH-1:0] rise;

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         sclk_q <= '0;
      end else begin
         sclk_q <= sclk_eff;
      end
   end

   genvar i;
   generate
      for (i = 0; i < NCH; i++) begin : g_ch
         // Shared variant drives every channel from the first clock pin
         assign sclk_eff[i] = SHARED_CLK ? LINK.sclk[0] : LINK.sclk[i]; // [RULE5]
         assign rise[i]     = sclk_eff[i] & ~sclk_q[i];
         qdl_channel #(.W(W)) u_ch (
            .clk      (REF_CLK),
            .rst      (RESET),
            .shift_en (rise[i]),
            .ser_in   (LINK.channel_serial_in[i]), // [RULE6]
            .load_n   (LINK.load_n[i]),
            .mode     (MODE),
            .code     (CODE[i*W +: W]),
            .neg      (OUT_NEG[i]),
            .mag      (CHANNEL_CURRENT_OUT[i*W +: W])
         );
      end
   endgenerate
endmodule
`default_nettype wire

// ==== logic/qdl_host.sv ====
// Host end: shifts a 12-bit code into each requested channel, then strobes its load
`include "qdl_defs.svh"
`default_nettype none
module qdl_host
   import qdl_pkg::*;
#(
   parameter int NCH = `QDL_NCH,
   parameter int W   = `QDL_CODE_W,
   parameter int DIV = `QDL_SCLK_DIV
) (
   input  wire logic          REF_CLK,
   input  wire logic          RESET,
   qdl_if.host                LINK,
   input  wire logic          REQ_VALID,
   output logic               REQ_READY,
   input  wire logic [NCH-1:0] REQ_CH_MASK,
   input  wire logic [NCH*W-1:0] REQ_CODES,
   input  wire logic          REQ_TWOS
);
   localparam int DLY = `QDL_LOAD_DELAY_CYC;
   qdl_hstate_e   state_q;
   logic [W-1:0]  data_q [NCH];
   logic [NCH-1:0] mask_q;
   logic [4:0]    bit_q;
   logic [7:0]    cnt_q;
   logic [NCH-1:0] sdo_q;
   logic          sclk_q;
   logic          load_q;
   logic          tick;

   assign tick      = (cnt_q == 8'(DIV - 1));
   assign REQ_READY = (state_q == QDL_IDLE);

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         cnt_q <= '0;
      end else if (state_q == QDL_IDLE) begin
         cnt_q <= '0;
      end else if (state_q == QDL_WAIT) begin
         // Settle gap may outlast one divider period, so the count must not wrap here
         cnt_q <= (cnt_q >= 8'(DLY)) ? 8'h00 : cnt_q + 8'd1; // [RULE4]
      end else if (tick) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_q + 8'd1;
      end
   end

   always_ff @(posedge REF_CLK or posedge RESET) begin
      if (RESET) begin
         state_q <= QDL_IDLE;
         bit_q   <= '0;
         sclk_q  <= 1'b0;
         load_q  <= 1'b0;
         mask_q  <= '0;
      end else begin
         unique case (state_q)
            QDL_IDLE: begin
               load_q <= 1'b0;
               if (REQ_VALID) begin
                  mask_q  <= REQ_CH_MASK;
                  bit_q   <= 5'(W);
                  state_q <= QDL_SHIFT_LO;
               end
            end
            QDL_SHIFT_LO: if (tick) begin
               sclk_q  <= 1'b1; // [RULE1]
               bit_q   <= bit_q - 5'd1;
               state_q <= QDL_SHIFT_HI;
            end
            QDL_SHIFT_HI: if (tick) begin
               sclk_q  <= 1'b0;
               state_q <= (bit_q == '0) ? QDL_WAIT : QDL_SHIFT_LO;
            end
            // Strobes stay high through shifting and the settle gap
            QDL_WAIT: if (cnt_q >= 8'(DLY)) begin // [RULE4] [RULE13]
               load_q  <= 1'b1; // [RULE2]
               state_q <= QDL_LOAD;
            end
            QDL_LOAD: if (tick) begin
               load_q  <= 1'b0;
               state_q <= QDL_IDLE;
            end
         endcase
      end
   end

   // Per-channel data; MSB presented first, flipped for twos complement
   genvar i;
   generate
      for (i = 0; i < NCH; i++) begin : g_d
         always_ff @(posedge REF_CLK or posedge RESET) begin
            if (RESET) begin
               data_q[i] <= '0;
               sdo_q[i]  <= 1'b0;
            end else if (state_q == QDL_IDLE && REQ_VALID) begin
               data_q[i] <= REQ_CODES[i*W +: W] ^ {REQ_TWOS, {(W-1){1'b0}}}; // [RULE11]
            end else if (state_q == QDL_SHIFT_LO && cnt_q == '0) begin
               sdo_q[i]  <= data_q[i][W-1]; // [RULE1]
               data_q[i] <= {data_q[i][W-2:0], 1'b0};
            end
         end
      end
   endgenerate

   // One common clock and strobe drive all selected channels together
   assign LINK.sclk              = {NCH{sclk_q}};       // [RULE8]
   assign LINK.channel_serial_in = sdo_q;
   assign LINK.load_n            = ~(mask_q & {NCH{load_q}}); // [RULE8]
endmodule
`default_nettype wire

// ==== logic/qdl_if.sv ====
// Serial link between host and quad DAC: clocks, data lines and load strobes
`default_nettype none
interface qdl_if;
   logic [3:0] channel_serial_in;
   logic [3:0] sclk;
   logic [3:0] load_n;
   modport host (output channel_serial_in, output sclk, output load_n);
   modport dev  (input channel_serial_in, input sclk, input load_n);
endinterface
`default_nettype wire

// ==== logic/qdl_pkg.sv ====
// Types shared by both ends of the quad serial DAC load interface
`default_nettype none
package qdl_pkg;
   typedef logic [11:0] qdl_code_t;
   typedef enum logic {QDL_UNIPOLAR, QDL_BIPOLAR} qdl_mode_e;
   typedef enum {QDL_IDLE, QDL_SHIFT_LO, QDL_SHIFT_HI, QDL_WAIT, QDL_LOAD} qdl_hstate_e;
endpackage
`default_nettype wire

// ==== tb/qdl_link_checker.sv ====
// Wire-level checks on the serial link between host and device ends
`default_nettype none
module qdl_link_checker (
   input  wire logic       REF_CLK,
   input  wire logic       RESET,
   input  wire logic [3:0] channel_serial_in,
   input  wire logic [3:0] sclk,
   input  wire logic [3:0] load_n
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);
   property p_clk_tied; sclk == {4{sclk[0]}}; endproperty
   a_clk_tied: assert property (p_clk_tied) else $error("clocks differ");
   property p_load_common; (load_n != 4'hf && $past(load_n) != 4'hf) |-> $stable(load_n); endproperty
   a_load_common: assert property (p_load_common) else $error("strobes split");
   property p_load_delay; $rose(sclk[0]) |-> (&load_n) [*4]; endproperty
   a_load_delay: assert property (p_load_delay) else $error("early strobe");
   // A strobe low while the clock moves would let outputs follow partial codes
   property p_hold_shift; !(&load_n) |-> !sclk[0] && $stable(sclk[0]); endproperty
   a_hold_shift: assert property (p_hold_shift) else $error("shift under strobe");
   property p_data_stable; sclk[0] |-> $stable(channel_serial_in); endproperty
   a_data_stable: assert property (p_data_stable) else $error("data moved");
   property p_high_width; $rose(sclk[0]) |-> sclk[0] [*4] ##1 !sclk[0]; endproperty
   a_high_width: assert property (p_high_width) else $error("bad high time");
   property p_low_width; $fell(sclk[0]) |-> (!sclk[0]) [*4]; endproperty
   a_low_width: assert property (p_low_width) else $error("short low time");
   property p_load_width; $fell(&load_n) |-> (load_n != 4'hf) [*4] ##1 (&load_n); endproperty
   a_load_width: assert property (p_load_width) else $error("bad strobe width");
endmodule
`default_nettype wire

// ==== tb/test_quad_serial_dac_load_interface.sv ====
// Bench: host and two device variants on one link, checked against a code model
`default_nettype none
module test_quad_serial_dac_load_interface import qdl_pkg::*; ();
   timeunit 1ns;
   timeprecision 1ps;
   logic        ref_clk = 1'b0;
   logic        reset = 1'b1;
   logic        req_valid = 1'b0;
   logic        req_ready;
   logic        req_twos = 1'b0;
   logic [3:0]  req_mask = 4'h0;
   logic [3:0]  neg;
   logic [47:0] req_codes = '0;
   logic [47:0] code;
   logic [47:0] code_s;
   logic [47:0] cur;
   logic [47:0] cur_s;
   logic [3:0]  neg_s;
   qdl_mode_e   mode = QDL_UNIPOLAR;
   logic [11:0] exp_q [4] = '{default: 12'h000};
   int          mismatches = 0;
   int          total_checks = 0;
   always #4 ref_clk = ~ref_clk;
   qdl_if lnk ();
   qdl_host i_qdl_host (.REF_CLK(ref_clk), .RESET(reset), .LINK(lnk.host),
      .REQ_VALID(req_valid), .REQ_READY(req_ready), .REQ_CH_MASK(req_mask),
      .REQ_CODES(req_codes), .REQ_TWOS(req_twos));
   qdl_device i_qdl_device (.REF_CLK(ref_clk), .RESET(reset), .LINK(lnk.dev),
      .MODE(mode), .CODE(code), .OUT_NEG(neg), .CHANNEL_CURRENT_OUT(cur));
   qdl_device #(.SHARED_CLK(1'b1)) i_qdl_device_shared (.REF_CLK(ref_clk), .RESET(reset),
      .LINK(lnk.dev), .MODE(mode), .CODE(code_s), .OUT_NEG(neg_s), .CHANNEL_CURRENT_OUT(cur_s));
   qdl_link_checker i_qdl_link_checker (.REF_CLK(ref_clk), .RESET(reset),
      .channel_serial_in(lnk.channel_serial_in), .sclk(lnk.sclk), .load_n(lnk.load_n));
   task automatic close_out();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic wait_ready(input logic lvl);
      int n;
      n = 0;
      while (req_ready !== lvl) begin
         tick();
         n++;
         if (n > 400) begin
            mismatches++;
            close_out();
         end
      end
   endtask
   task automatic compare();
      for (int md = 0; md < 2; md++) begin
         mode = qdl_mode_e'(md);
         tick();
         for (int i = 0; i < 4; i++) begin
            logic [11:0] e;
            logic [11:0] mg;
            e = exp_q[i];
            mg = (md == 0) ? e : (e[11] ? e - 12'h800 : 12'h800 - e);
            chk(code[12*i +: 12], e);
            chk(code_s[12*i +: 12], e);
            chk(cur[12*i +: 12], mg);
            chk(cur_s[12*i +: 12], mg);
            if (mg != 12'h000) chk({11'h0, neg_s[i]}, {11'h0, (md == 0) | ~e[11]});
            // Sign of a zero output is left open, so it is not compared
            if (mg != 12'h000) chk({11'h0, neg[i]}, {11'h0, (md == 0) | ~e[11]});
         end
      end
   endtask
   task automatic send(input logic [3:0] m, input logic [47:0] c, input logic t);
      wait_ready(1'b1);
      req_mask = m;
      req_codes = c;
      req_twos = t;
      req_valid = 1'b1;
      tick();
      req_valid = 1'b0;
      for (int i = 0; i < 4; i++) if (m[i]) exp_q[i] = c[12*i +: 12] ^ {t, 11'h0};
      wait_ready(1'b0);
      wait_ready(1'b1);
      tick();
      compare();
   endtask
   function automatic logic [47:0] rnd();
      return {$urandom, 16'($urandom)};
   endfunction
   initial begin
      void'($urandom(32'ha0aa2b95));
      repeat (5) @(posedge ref_clk);
      #1;
      reset = 1'b0;
      compare();
      $display("test reset_values done");
      send(4'hf, rnd(), 1'b0);
      $display("test all_channels done");
      for (int i = 0; i < 4; i++) send(4'(1 << i), rnd(), 1'b0);
      $display("test single_channel done");
      send(4'hf, rnd(), 1'b1);
      send(4'h5, rnd(), 1'b1);
      $display("test twos_complement done");
      send(4'hf, {12'h7ff, 12'hfff, 12'h800, 12'h001}, 1'b0);
      send(4'hf, {12'h801, 12'h000, 12'h7ff, 12'h800}, 1'b0);
      $display("test boundary_codes done");
      reset = 1'b1;
      tick();
      reset = 1'b0;
      exp_q = '{default: 12'h000};
      compare();
      send(4'ha, rnd(), 1'b0);
      $display("test mid_reset done");
      close_out();
   end
endmodule
`default_nettype wire
